// ===== fps_pkg.sv
// package of offsets, field layouts and constants for the flash partition size registers
package fps_pkg;
  // ==========================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [11:0] FPS_OFF_USER_BASE = 12'h000;
  localparam logic [11:0] FPS_OFF_PROG_SIZE = 12'h004;
  localparam logic [11:0] FPS_OFF_BOOT_SIZE = 12'h008;
  localparam logic [11:0] FPS_OFF_GEOMETRY = 12'h00c;
  // ==========================================================
  // user program base field
  localparam int FPS_BASE_LSB = 11;
  localparam int FPS_BASE_MSB = 19;
  localparam int FPS_BASE_WIDTH = 9;
  localparam logic [8:0] FPS_BASE_RESET = 9'h000;
  // ==========================================================
  // fixed sizes in bytes
  localparam logic [31:0] FPS_PROG_SIZE_16K = 32'h0000_4000;
  localparam logic [31:0] FPS_PROG_SIZE_32K = 32'h0000_8000;
  localparam logic [31:0] FPS_PROG_SIZE_64K = 32'h0001_0000;
  localparam logic [31:0] FPS_PROG_SIZE_128K = 32'h0002_0000;
  localparam logic [31:0] FPS_PROG_SIZE_256K = 32'h0004_0000;
  localparam logic [31:0] FPS_BOOT_SIZE = 32'h0000_0c00;
  // array geometry: page 1 KB, row 128 bytes
  localparam logic [15:0] FPS_PAGE_BYTES = 16'h0400;
  localparam logic [15:0] FPS_ROW_BYTES = 16'h0080;
  localparam logic [31:0] FPS_READ_ZERO = 32'h0000_0000;
endpackage : fps_pkg

// ===== fps_ro_word.sv
// read-only constant word with a compare against a read address
`timescale 1ns/1ps
module fps_ro_word
  import fps_pkg::*;
#(
  parameter logic [11:0] OFFSET = 12'h000,
  parameter logic [31:0] VALUE = 32'h0000_0000
) (
  // access
  input wire logic [11:0] addr,
  // result
  output logic hit,
  output logic [31:0] word
);
  assign hit = (addr == OFFSET);
  assign word = hit ? VALUE : FPS_READ_ZERO;
endmodule : fps_ro_word

// ===== fps_flash_partition_regs.sv
// apb register bank for program flash partition base and flash sizes
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fps_flash_partition_regs
  import fps_pkg::*;
#(
  parameter logic [31:0] PROG_SIZE = FPS_PROG_SIZE_256K
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // partition outputs
  output logic [31:0] userBaseAddr,
  output logic userRegionEnabled
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [8:0] baseField;
    logic [31:0] readData;
    logic slvErr;
  } fps_state_type;

  fps_state_type state;
  fps_state_type next_state;
  logic setupCycle;
  logic [31:0] userBaseWord;
  logic progHit;
  logic bootHit;
  logic [31:0] progWord;
  logic [31:0] bootWord;
  logic knownAddr;
  logic accessPhase;
  logic baseWrite;
  logic readSetup;
  logic unmappedAddr;

  // ==========================================================
  // read-only size words
  fps_ro_word #(.OFFSET(FPS_OFF_PROG_SIZE), .VALUE(PROG_SIZE)) uProgSize (
    .addr(paddr),
    .hit(progHit),
    .word(progWord)
  );
  fps_ro_word #(.OFFSET(FPS_OFF_BOOT_SIZE), .VALUE(FPS_BOOT_SIZE)) uBootSize (
    .addr(paddr),
    .hit(bootHit),
    .word(bootWord)
  );

  // ==========================================================
  // decode
  assign setupCycle = psel && !penable;
  // high and low bits forced to zero on the base word
  assign userBaseWord = {12'h000, state.baseField, 11'h000};
  assign knownAddr = progHit || bootHit || (paddr == FPS_OFF_USER_BASE) ||
                     (paddr == FPS_OFF_GEOMETRY);
  assign accessPhase = psel && penable;
  assign baseWrite = accessPhase && pwrite && (paddr == FPS_OFF_USER_BASE);
  assign readSetup = setupCycle && !pwrite;
  assign unmappedAddr = !knownAddr;

  always_comb begin
    next_state = state;
    if (setupCycle) begin
      next_state.slvErr = !knownAddr;
      next_state.readData = FPS_READ_ZERO;
      if (!pwrite) begin
        if (paddr == FPS_OFF_USER_BASE) begin
          next_state.readData = userBaseWord;
        end else if (paddr == FPS_OFF_GEOMETRY) begin
          next_state.readData = {FPS_PAGE_BYTES, FPS_ROW_BYTES};
        end else begin
          next_state.readData = progWord | bootWord;
        end
      end
    end
    // write lands at the access edge; only bits 19..11 are stored
    if (psel && penable && pwrite && paddr == FPS_OFF_USER_BASE) begin
      if (pstrb[1]) begin
        next_state.baseField[4:0] = pwdata[15:11];
      end
      if (pstrb[2]) begin
        next_state.baseField[8:5] = pwdata[19:16];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign pready = psel && penable;
  assign prdata = state.readData;
  assign pslverr = psel && penable && state.slvErr;
  assign userBaseAddr = userBaseWord;
  // the device trusts software to keep the base within the array
  assign userRegionEnabled = (state.baseField != FPS_BASE_RESET);

  // ==========================================================
  // checks: stored base word
  chk_base_low_zero: assert property (@(posedge core_clk) disable iff (rst)
    userBaseAddr[10:0] == 11'h000 && userBaseAddr[31:20] == 12'h000)
    else $error("base reserved bits not zero");

  chk_base_write_lands: assert property (@(posedge core_clk) disable iff (rst)
    baseWrite && pstrb[2] && pstrb[1]
    |=> userBaseAddr[19:11] == $past(pwdata[19:11]))
    else $error("base write not stored");

  chk_base_partial_low: assert property (@(posedge core_clk) disable iff (rst)
    baseWrite && pstrb[1] && !pstrb[2]
    |=> userBaseAddr[15:11] == $past(pwdata[15:11]) &&
    userBaseAddr[19:16] == $past(userBaseAddr[19:16]))
    else $error("base low lane write wrong");

  chk_base_partial_high: assert property (@(posedge core_clk) disable iff (rst)
    baseWrite && pstrb[2] && !pstrb[1]
    |=> userBaseAddr[19:16] == $past(pwdata[19:16]) &&
    userBaseAddr[15:11] == $past(userBaseAddr[15:11]))
    else $error("base high lane write wrong");

  chk_base_no_strobe: assert property (@(posedge core_clk) disable iff (rst)
    baseWrite && !pstrb[1] && !pstrb[2] |=> $stable(userBaseAddr))
    else $error("base changed without strobes");

  chk_base_holds: assert property (@(posedge core_clk) disable iff (rst)
    !(psel && penable && pwrite && paddr == FPS_OFF_USER_BASE) |=> $stable(userBaseAddr))
    else $error("base changed without a write");

  chk_enable_after_write: assert property (@(posedge core_clk) disable iff (rst)
    baseWrite && pstrb[2] && pstrb[1] && pwdata[19:11] != 9'h000
    |=> userRegionEnabled)
    else $error("user region not enabled by base write");

  chk_reset_clears: assert property (@(posedge core_clk)
    $fell(rst) |-> userBaseAddr == 32'h0000_0000 && !userRegionEnabled)
    else $error("base not cleared by reset");

  chk_reset_read_zero: assert property (@(posedge core_clk)
    $fell(rst) |-> prdata == FPS_READ_ZERO && !pslverr)
    else $error("read path not cleared by reset");

  // ==========================================================
  // checks: register reads
  chk_prog_size_read: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && !pwrite && paddr == FPS_OFF_PROG_SIZE ##1 penable |-> prdata == PROG_SIZE)
    else $error("program size read wrong");

  chk_boot_size_read: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && !pwrite && paddr == FPS_OFF_BOOT_SIZE ##1 penable |-> prdata == 32'h0000_0c00)
    else $error("boot size read wrong");

  chk_geometry_read: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && !pwrite && paddr == FPS_OFF_GEOMETRY ##1 penable |-> prdata == 32'h0400_0080)
    else $error("geometry read wrong");

  chk_base_read_back: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && !pwrite && paddr == FPS_OFF_USER_BASE ##1 penable
    |-> prdata[31:20] == 12'h000 && prdata[10:0] == 11'h000)
    else $error("base read shows reserved bits");

  chk_base_read_value: assert property (@(posedge core_clk) disable iff (rst)
    readSetup && paddr == FPS_OFF_USER_BASE ##1 penable |-> prdata == userBaseAddr)
    else $error("base read differs from stored base");

  chk_read_data_holds: assert property (@(posedge core_clk) disable iff (rst)
    !setupCycle |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

  // ==========================================================
  // checks: bus answer
  chk_unmapped_error: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && unmappedAddr ##1 penable |-> pslverr && prdata == FPS_READ_ZERO)
    else $error("unmapped access not refused");

  chk_mapped_no_error: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && !unmappedAddr ##1 penable |-> !pslverr)
    else $error("mapped access refused");

  chk_ro_write_quiet: assert property (@(posedge core_clk) disable iff (rst)
    setupCycle && pwrite && (progHit || bootHit) ##1 penable
    |-> !pslverr && $stable(userBaseAddr))
    else $error("size register write had an effect");

  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !psel |-> !pready && !pslverr)
    else $error("answer outside a transfer");

  // ==========================================================
  // coverage of the main scenarios
  cov_base_write: cover property (@(posedge core_clk) disable iff (rst)
    psel && penable && pwrite && paddr == FPS_OFF_USER_BASE);

  cov_size_read: cover property (@(posedge core_clk) disable iff (rst)
    psel && penable && !pwrite && paddr == FPS_OFF_PROG_SIZE);

  cov_bad_addr: cover property (@(posedge core_clk) disable iff (rst) pslverr);

  cov_partial_strobe: cover property (@(posedge core_clk) disable iff (rst)
    baseWrite && (pstrb[1] != pstrb[2]));

  cov_reset_after_write: cover property (@(posedge core_clk)
    baseWrite ##[1:3] rst);
endmodule : fps_flash_partition_regs

// ===== flash_partition_size_regs_tb.sv
// self-checking bench for the flash partition size register bank
`timescale 1ns/1ps
module flash_partition_size_regs_tb;
  import fps_pkg::*;
  // ==========================================================
  // design hookup
  logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, userBaseAddr, seed = 32'h23, base = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, userRegionEnabled;
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  fps_flash_partition_regs uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .userBaseAddr(userBaseAddr),
    .userRegionEnabled(userRegionEnabled));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // strobed merge of a write into the base field
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] st);
    logic [31:0] m;
    m = {12'h000, {4{st[2]}}, {5{st[1]}}, 11'h000};
    return (old & ~m) | (wd & m);
  endfunction : merge
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] st,
      output logic [31:0] rd, output logic err);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================================
  // tests
  initial begin
    logic [31:0] rd, wd, tmp;
    logic [3:0] st;
    logic err;
    logic [11:0] ro_off [3] = '{FPS_OFF_PROG_SIZE, FPS_OFF_BOOT_SIZE, FPS_OFF_GEOMETRY};
    logic [31:0] ro_val [3] = '{FPS_PROG_SIZE_256K, FPS_BOOT_SIZE,
      {FPS_PAGE_BYTES, FPS_ROW_BYTES}};
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    apb(1'h0, FPS_OFF_USER_BASE, 32'h0, 4'h0, rd, err);
    chk("base at reset", 32'h0, rd);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, ro_off[i], 32'hffffffff, 4'hf, rd, err);
      chk("fixed write error", 32'h0, {31'h0, err});
      apb(1'h0, ro_off[i], 32'h0, 4'h0, rd, err);
      chk("fixed word", ro_val[i], rd);
    end
    $display("test fixed words done");
    for (int i = 0; i < 40; i++) begin
      wd = rnd() & 32'hfff3ffff; // keep the base within program flash
      tmp = rnd();
      st = (i < 2) ? 4'hf : tmp[3:0];
      if (i == 0) wd = 32'hfff3ffff;
      apb(1'h1, FPS_OFF_USER_BASE, wd, st, rd, err);
      base = merge(base, wd, st);
      apb(1'h0, FPS_OFF_USER_BASE, 32'h0, 4'h0, rd, err);
      chk("base readback", base, rd);
      chk("base read error", 32'h0, {31'h0, err});
      chk("base output", base, userBaseAddr);
      chk("user enable", {31'h0, base != 32'h0}, {31'h0, userRegionEnabled});
    end
    $display("test base writes done");
    apb(1'h1, 12'h010, 32'hffffffff, 4'hf, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'h0, 12'h010, 32'h0, 4'h0, rd, err);
    chk("unmapped data", 32'h0, rd);
    chk("base kept", base, userBaseAddr);
    chk("ready idle", 32'h0, {31'h0, pready});
    $display("test unmapped done");
    apb(1'h1, FPS_OFF_USER_BASE, 32'h0001f800, 4'hf, rd, err);
    rst <= 1'h1;
    @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    chk("base after reset", 32'h0, userBaseAddr);
    apb(1'h0, FPS_OFF_USER_BASE, 32'h0, 4'h0, rd, err);
    chk("base read after reset", 32'h0, rd);
    $display("test second reset done");
    results();
  end
endmodule : flash_partition_size_regs_tb
